// ### clk_supervisor_consts.vh
`ifndef CLK_SUPERVISOR_CONSTS_VH
`define CLK_SUPERVISOR_CONSTS_VH
// Register word indices; a register's bus byte address is four times its index
`define OFS_OSC_CONTROL 8'h8f
`define OFS_PERIPH_FLAG 8'h03
`define OFS_PERIPH_ENABLE 8'h04
`define OFS_CONFIG 8'h05
`define OFS_STATUS 8'h06
`define OFS_SLEEP_CMD 8'h07
// Oscillator control fields
`define OSC_FREQ_MSB 6
`define OSC_FREQ_LSB 4
`define OSC_TIMEOUT_BIT 3
`define OSC_HF_STABLE_BIT 2
`define OSC_LF_STABLE_BIT 1
`define OSC_SYS_SEL_BIT 0
`define OSC_FREQ_RESET 3'h6
// Peripheral flag and enable bit
`define OSC_FAIL_BIT 2
// Configuration word fields
`define CFG_MODE_MSB 2
`define CFG_MODE_LSB 0
`define CFG_SWITCHOVER_BIT 3
`define CFG_MONITOR_EN_BIT 4
`define CFG_PWRUP_EN_BIT 5
`define CFG_RESET 8'h00
// Oscillator modes
`define MODE_LP 3'h0
`define MODE_XT 3'h1
`define MODE_HS 3'h2
`define MODE_EC 3'h3
// Timing
`define STARTUP_CYCLES 11'h400
`define SAMPLE_DIV 7'h40
`define PWRUP_TIME_US 64
`define CLK_MHZ 125
`define PWRUP_CYCLES ((`PWRUP_TIME_US) * (`CLK_MHZ))
`endif

// ### edge_sync.v
module edge_sync (
  input wire clk_sys,
  input wire rstn,
  input wire sigIn,
  output reg level,
  output reg rise,
  output reg fall
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1_ff <= sigIn;
      s2_ff <= s1_ff;
      level <= s2_ff;
      rise <= s2_ff & ~level;
      fall <= ~s2_ff & level;
    end
  end
endmodule // edge_sync

// ### clock_supervisor.v
// The AXI4-Lite interface to the registers is this design's own decision.
`include "clk_supervisor_consts.vh"
module clock_supervisor #(
  parameter PWRUP_CYCLES = `PWRUP_CYCLES
) (
  input wire clk_sys,
  input wire rstn,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire extOsc,
  input wire internalRcClock,
  input wire hfInternalStable,
  input wire lfInternalStable,
  input wire sleepEnter,
  input wire wakeUp,
  output reg useExternalClk,
  output reg sysClkHold,
  output reg [2:0] internalFreqSelect,
  output reg watchdogClear,
  output reg oscFailIrq
);
  localparam ST_PWRUP = 3'h0;
  localparam ST_COUNT = 3'h1;
  localparam ST_WAIT_INT = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_RUN = 3'h4;
  localparam ST_SLEEP = 3'h5;

  reg rs1_ff;
  reg rst_ff;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rs1_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_ff <= rs1_ff;
    end
  end
  wire rn = rst_ff;

  wire extLevel;
  wire extRise;
  wire extFall;
  wire rcLevel;
  wire rcRise;
  wire rcFall;
  edge_sync u_ext (
    .clk_sys(clk_sys),
    .rstn(rn),
    .sigIn(extOsc),
    .level(extLevel),
    .rise(extRise),
    .fall(extFall)
  );
  edge_sync u_rc (
    .clk_sys(clk_sys),
    .rstn(rn),
    .sigIn(internalRcClock),
    .level(rcLevel),
    .rise(rcRise),
    .fall(rcFall)
  );

  reg [7:0] config_ff;
  reg [2:0] freq_ff;
  reg sysSel_ff;
  reg timeout_ff;
  reg failFlag_ff;
  reg failIrqEn_ff;
  reg failSafe_ff;
  reg [2:0] state_ff;
  reg [10:0] ostCnt_ff;
  reg [31:0] pwrCnt_ff;
  reg [5:0] divCnt_ff;
  reg sampleClk_ff;
  reg monLatch_ff;
  reg monArmed_ff;

  wire [2:0] oscMode = config_ff[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire crystalMode = (oscMode == `MODE_LP) | (oscMode == `MODE_XT) | (oscMode == `MODE_HS);
  wire monEn = config_ff[`CFG_MONITOR_EN_BIT];
  // Monitor forces two-speed behaviour; internal-select bypasses it
  wire twoSpeed = (config_ff[`CFG_SWITCHOVER_BIT] | monEn) & ~sysSel_ff & crystalMode;

  // Register bus write path: address and data accepted in either order
  reg awHave_ff;
  reg wHave_ff;
  reg [7:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  wire doWrite = awHave_ff & wHave_ff & ~s_axi_bvalid;
  wire wrLane0 = doWrite & wStrb_ff[0];
  wire wrOsc = wrLane0 & (awAddr_ff == `OFS_OSC_CONTROL);
  wire wrFlag = wrLane0 & (awAddr_ff == `OFS_PERIPH_FLAG);
  wire wrEn = wrLane0 & (awAddr_ff == `OFS_PERIPH_ENABLE);
  wire wrCfg = wrLane0 & (awAddr_ff == `OFS_CONFIG);
  wire wrSleep = wrLane0 & (awAddr_ff == `OFS_SLEEP_CMD) & wData_ff[0];
  wire mapped = (awAddr_ff == `OFS_OSC_CONTROL) | (awAddr_ff == `OFS_PERIPH_FLAG) |
                (awAddr_ff == `OFS_PERIPH_ENABLE) | (awAddr_ff == `OFS_CONFIG) |
                (awAddr_ff == `OFS_SLEEP_CMD) | (awAddr_ff == `OFS_STATUS);
  wire selChange = wrOsc & (wData_ff[`OSC_SYS_SEL_BIT] != sysSel_ff);
  wire goSleep = sleepEnter | wrSleep;

  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~awHave_ff & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHave_ff & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped ? 2'h0 : 2'h3;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers and fail-safe
  wire failDetect;
  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      config_ff <= `CFG_RESET;
      freq_ff <= `OSC_FREQ_RESET;
      sysSel_ff <= 1'b0;
      failIrqEn_ff <= 1'b0;
      failFlag_ff <= 1'b0;
      failSafe_ff <= 1'b0;
    end else begin
      if (wrCfg)
        config_ff <= wData_ff[7:0];
      if (wrOsc) begin
        freq_ff <= wData_ff[`OSC_FREQ_MSB:`OSC_FREQ_LSB];
        sysSel_ff <= wData_ff[`OSC_SYS_SEL_BIT];
      end
      if (wrEn)
        failIrqEn_ff <= wData_ff[`OSC_FAIL_BIT];
      if (failDetect) begin
        failSafe_ff <= 1'b1;
      end else if (selChange | goSleep) begin
        failSafe_ff <= 1'b0;
      end
      // Set wins over clear; clear ignored during fail-safe
      if (failDetect)
        failFlag_ff <= 1'b1;
      else if (wrFlag & ~wData_ff[`OSC_FAIL_BIT] & ~failSafe_ff)
        failFlag_ff <= 1'b0;
      else if (wrFlag & wData_ff[`OSC_FAIL_BIT])
        failFlag_ff <= 1'b1;
    end
  end

  // Start-up sequencer
  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      state_ff <= ST_PWRUP;
      ostCnt_ff <= 11'h0;
      pwrCnt_ff <= 32'h0;
      timeout_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_PWRUP: begin
          if (config_ff[`CFG_PWRUP_EN_BIT] && pwrCnt_ff < PWRUP_CYCLES - 1) begin
            pwrCnt_ff <= pwrCnt_ff + 32'h1;
          end else begin
            ostCnt_ff <= 11'h0;
            state_ff <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (!crystalMode) begin
            state_ff <= ST_HOLD;
          end else if (extFall) begin
            if (ostCnt_ff == `STARTUP_CYCLES - 11'h1)
              state_ff <= twoSpeed ? ST_WAIT_INT : ST_HOLD;
            ostCnt_ff <= ostCnt_ff + 11'h1;
          end
        end
        ST_WAIT_INT: begin
          if (rcFall) begin
            timeout_ff <= 1'b1;
            state_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (extFall | ~crystalMode) begin
            timeout_ff <= 1'b1;
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (failDetect)
            timeout_ff <= 1'b0;
        end
        default: begin
          if (wakeUp) begin
            ostCnt_ff <= 11'h0;
            state_ff <= ST_COUNT;
          end
        end
      endcase
      if (goSleep) begin
        timeout_ff <= 1'b0;
        state_ff <= ST_SLEEP;
      end
    end
  end

  // Sample clock: internal RC divided by 64
  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      divCnt_ff <= 6'h0;
      sampleClk_ff <= 1'b0;
    end else if (rcRise) begin
      divCnt_ff <= divCnt_ff + 6'h1;
      if (divCnt_ff == `SAMPLE_DIV / 2 - 1)
        sampleClk_ff <= ~sampleClk_ff;
      if (divCnt_ff == 6'h3f)
        sampleClk_ff <= ~sampleClk_ff;
    end
  end

  reg samplePrev_ff;
  wire sampleRise = sampleClk_ff & ~samplePrev_ff;
  wire sampleFall = ~sampleClk_ff & samplePrev_ff;
  wire monActive = monEn & (state_ff == ST_RUN) & ~failSafe_ff;
  assign failDetect = monActive & monArmed_ff & sampleFall & ~monLatch_ff;
  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      samplePrev_ff <= 1'b0;
      monLatch_ff <= 1'b0;
      monArmed_ff <= 1'b0;
    end else begin
      samplePrev_ff <= sampleClk_ff;
      // First check only at the sample fall after a sample rise has cleared the latch
      if (!monActive)
        monArmed_ff <= 1'b0;
      else if (sampleRise)
        monArmed_ff <= 1'b1;
      if (extFall)
        monLatch_ff <= 1'b1;
      else if (sampleRise)
        monLatch_ff <= 1'b0;
    end
  end

  // Outputs
  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      useExternalClk <= 1'b0;
      sysClkHold <= 1'b0;
      internalFreqSelect <= `OSC_FREQ_RESET;
      watchdogClear <= 1'b0;
      oscFailIrq <= 1'b0;
    end else begin
      useExternalClk <= (state_ff == ST_RUN) & ~sysSel_ff & ~failSafe_ff & ~failDetect;
      sysClkHold <= (state_ff == ST_HOLD);
      internalFreqSelect <= freq_ff;
      watchdogClear <= failDetect;
      oscFailIrq <= failFlag_ff & failIrqEn_ff;
    end
  end

  // Read path
  reg [7:0] rdByte;
  always @* begin
    rdByte = 8'h00;
    if (s_axi_araddr[9:2] == `OFS_OSC_CONTROL)
      rdByte = {1'b0, freq_ff, timeout_ff, hfInternalStable, lfInternalStable, sysSel_ff};
    else if (s_axi_araddr[9:2] == `OFS_PERIPH_FLAG)
      rdByte = {5'h0, failFlag_ff, 2'h0};
    else if (s_axi_araddr[9:2] == `OFS_PERIPH_ENABLE)
      rdByte = {5'h0, failIrqEn_ff, 2'h0};
    else if (s_axi_araddr[9:2] == `OFS_CONFIG)
      rdByte = config_ff;
    else if (s_axi_araddr[9:2] == `OFS_STATUS)
      rdByte = {monLatch_ff, rcLevel, failSafe_ff, 2'h0, state_ff};
  end
  wire rdMapped = (s_axi_araddr[9:2] == `OFS_OSC_CONTROL) |
                  (s_axi_araddr[9:2] == `OFS_PERIPH_FLAG) |
                  (s_axi_araddr[9:2] == `OFS_PERIPH_ENABLE) |
                  (s_axi_araddr[9:2] == `OFS_CONFIG) |
                  (s_axi_araddr[9:2] == `OFS_STATUS) |
                  (s_axi_araddr[9:2] == `OFS_SLEEP_CMD);
  always @(posedge clk_sys or negedge rn) begin
    if (!rn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, rdByte};
        s_axi_rresp <= rdMapped ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // clock_supervisor

// ### clock_supervisor_asserts.sv
module clock_supervisor_asserts (
  input wire clk_sys,
  input wire rstn,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire useExternalClk,
  input wire sysClkHold,
  input wire [2:0] internalFreqSelect,
  input wire watchdogClear,
  input wire oscFailIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [2:0] wrAge_ff;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Saturating age of the last data beat; the field may only move shortly after one
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrAge_ff <= 3'h7;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wrAge_ff <= 3'h0;
    end else if (wrAge_ff != 3'h7) begin
      wrAge_ff <= wrAge_ff + 3'h1;
    end
  end
  property p_freq_reset;
    $rose(rstn) |-> internalFreqSelect == 3'h6;
  endproperty
  a_freq_reset: assert property (p_freq_reset) else $error("frequency field not 110 at reset");
  property p_freq_write_only;
    !$stable(internalFreqSelect) |-> wrAge_ff < 3'h6;
  endproperty
  a_freq_write_only: assert property (p_freq_write_only) else $error("frequency moved unasked");
  property p_hold_end;
    $fell(sysClkHold) |-> useExternalClk;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold ended without external clock");
  property p_hold_bound;
    $rose(sysClkHold) |-> ##[1:40] !sysClkHold;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("clock hold too long");
  property p_fs_internal;
    watchdogClear |-> ##[0:3] !useExternalClk;
  endproperty
  a_fs_internal: assert property (p_fs_internal) else $error("no fallback after failure");
  property p_wdt_pulse;
    watchdogClear |=> !watchdogClear;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog clear not one pulse");
  property p_bvalid_hold;
    $fell(s_axi_bvalid) |-> $past(s_axi_bready) && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rvalid_hold;
    $fell(s_axi_rvalid) |-> $past(s_axi_rready) && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
  c_switch: cover property ($rose(useExternalClk));
  c_fail: cover property (watchdogClear);
  c_irq: cover property ($rose(oscFailIrq));
endmodule // clock_supervisor_asserts

// ### ext_osc_model.sv
module ext_osc_model #(
  parameter int HALF_NS = 23
) (
  input wire run,
  output logic extOsc
);
  timeunit 1ns;
  timeprecision 1ps;
  // A dead crystal parks the pin at its last level, so a stop looks like a failure
  initial begin
    extOsc = 1'b0;
    // Half-nanosecond phase keeps pin edges off the system clock edges
    #0.5;
    forever #(HALF_NS) if (run) extOsc = ~extOsc;
  end
endmodule // ext_osc_model

// ### clock_supervisor_tb.sv
`include "clk_supervisor_consts.vh"
module clock_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rstn = 1'b0, extRun = 1'b0, internalRcClock = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, extOsc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
  logic hfInternalStable = 1'b1, lfInternalStable = 1'b1, sleepEnter = 1'b0, wakeUp = 1'b0;
  logic useExternalClk, sysClkHold, watchdogClear, oscFailIrq;
  logic [2:0] internalFreqSelect;
  int nFail = 0, checkCount = 0, extCount = 0;
  always #4 clk_sys = ~clk_sys;
  // Fast stand-in for the 31 kHz source keeps the 64-fold sample period short
  always begin
    repeat (4) @(posedge clk_sys);
    internalRcClock <= ~internalRcClock;
  end
  always @(posedge extOsc) extCount++;
  ext_osc_model osc_u (.run(extRun), .extOsc(extOsc));
  clock_supervisor #(.PWRUP_CYCLES(10)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .extOsc(extOsc), .internalRcClock(internalRcClock), .hfInternalStable(hfInternalStable),
    .lfInternalStable(lfInternalStable), .sleepEnter(sleepEnter), .wakeUp(wakeUp),
    .useExternalClk(useExternalClk), .sysClkHold(sysClkHold),
    .internalFreqSelect(internalFreqSelect), .watchdogClear(watchdogClear),
    .oscFailIrq(oscFailIrq));
  task automatic finishTest;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Tasks take the register index; response ready goes up with the request
  // and drops once the answer is sampled, then one edge passes before the next call
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {a, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    while (!s_axi_bvalid) begin
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      @(posedge clk_sys);
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic axiRd(input logic [7:0] a);
    s_axi_araddr <= {a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    while (!s_axi_rvalid) begin
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      @(posedge clk_sys);
    end
    rdVal = s_axi_rdata;
    rdResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    axiRd(a);
    chk(nm, rdVal, exp);
  endtask
  task automatic sleepWake;
    sleepEnter <= 1'b1;
    @(posedge clk_sys);
    sleepEnter <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wakeUp <= 1'b1;
    @(posedge clk_sys);
    wakeUp <= 1'b0;
    extCount = 0;
  endtask
  initial begin
    #400000;
    nFail++;
    finishTest;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rdChk("osc_reset", `OFS_OSC_CONTROL, 32'h66);
    axiRd(8'h40);
    chk("unmapped_resp", {30'h0, rdResp}, 32'h3);
    lfInternalStable <= 1'b0;
    rdChk("lf_stable", `OFS_OSC_CONTROL, 32'h64);
    axiWr(`OFS_CONFIG, 32'h09);
    extRun = 1'b1;
    sleepWake;
    repeat (20) @(posedge clk_sys);
    chk("startup_internal", {31'h0, useExternalClk}, 32'h0);
    while (!sysClkHold) @(posedge clk_sys);
    chk("hold_internal", {31'h0, useExternalClk}, 32'h0);
    while (!useExternalClk) @(posedge clk_sys);
    chk("hold_released", {31'h0, sysClkHold}, 32'h0);
    chk("ost_count", {31'h0, extCount >= 1024 && extCount < 1040}, 32'h1);
    rdChk("timeout_set", `OFS_OSC_CONTROL, 32'h6c);
    axiWr(`OFS_CONFIG, 32'h19);
    repeat (300) @(posedge clk_sys);
    extRun = 1'b0;
    while (!watchdogClear) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk("fallback", {31'h0, useExternalClk}, 32'h0);
    chk("wdt_pulse", {31'h0, watchdogClear}, 32'h0);
    rdChk("timeout_clr", `OFS_OSC_CONTROL, 32'h64);
    rdChk("fail_flag", `OFS_PERIPH_FLAG, 32'h4);
    chk("irq_masked", {31'h0, oscFailIrq}, 32'h0);
    axiWr(`OFS_PERIPH_ENABLE, 32'h4);
    chk("irq_on", {31'h0, oscFailIrq}, 32'h1);
    axiWr(`OFS_PERIPH_FLAG, 32'h0);
    rdChk("flag_kept", `OFS_PERIPH_FLAG, 32'h4);
    axiWr(`OFS_OSC_CONTROL, 32'h20);
    chk("freq_fs", {29'h0, internalFreqSelect}, 32'h2);
    extRun = 1'b1;
    repeat (300) @(posedge clk_sys);
    chk("stay_internal", {31'h0, useExternalClk}, 32'h0);
    rdChk("still_fs", `OFS_PERIPH_FLAG, 32'h4);
    axiWr(`OFS_OSC_CONTROL, 32'h21);
    axiWr(`OFS_PERIPH_FLAG, 32'h0);
    rdChk("flag_cleared", `OFS_PERIPH_FLAG, 32'h0);
    chk("irq_off", {31'h0, oscFailIrq}, 32'h0);
    chk("sel_internal", {31'h0, useExternalClk}, 32'h0);
    axiWr(`OFS_CONFIG, 32'h13);
    axiWr(`OFS_OSC_CONTROL, 32'h60);
    sleepWake;
    while (!useExternalClk) @(posedge clk_sys);
    chk("ec_direct", {31'h0, extCount < 100}, 32'h1);
    axiWr(`OFS_OSC_CONTROL, 32'h10);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdChk("osc_rerst", `OFS_OSC_CONTROL, 32'h64);
    finishTest;
  end
endmodule // clock_supervisor_tb
bind clock_supervisor clock_supervisor_asserts chk_u (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .useExternalClk(useExternalClk), .sysClkHold(sysClkHold),
  .internalFreqSelect(internalFreqSelect), .watchdogClear(watchdogClear),
  .oscFailIrq(oscFailIrq));
